// >>> hdl/dma_channel_control.sv
// Multi-channel DMA control: per-channel registers over APB, priority
// arbitration, a two-phase read/write bus master and status flags.
// Assumes peripheral requests and the system bus run on pclk.
//
// Behaviour
// - Configuration bit 0 enables the channel; 0 keeps it idle.
// - Bit 1 gates the complete interrupt of the channel.
// - Bit 2 gates the halfway interrupt of the channel.
// - Bit 3 gates the error interrupt of the channel.
// - Bit 4 picks direction: 0 peripheral to memory, 1 the reverse.
// - Bit 5 enables wraparound operation.
// - Bit 6 steps the peripheral address after each item.
// - Bit 7 steps the memory address after each item.
// - Bits 9:8 set peripheral width; unused low address bits ignored.
// - Bits 11:10 set memory width; unused low address bits ignored.
// - Bits 13:12 rank the channel, low to very high.
// - Bit 14 selects memory copy, which needs no peripheral request.
// - Count is 16 bits, writable only while the channel is disabled.
// - While enabled the count is read-only and shows items remaining.
// - Count drops by one after each completed item.
// - At zero the count stays, or reloads in wraparound mode.
// - A channel with zero count serves nothing.
// - Peripheral and memory address registers hold 32-bit bases.
// - Writing 1 to a channel's clear-all bit clears all flags of that channel.
// - Writing 1 to a single clear bit clears only that flag.
//
// Design decision made here: register access over APB.
`default_nettype none
module dma_channel_control
    import dma_channel_pkg::*;
#(
    parameter int NCH = 4
) (
    // Clock and reset
    input  wire logic                             pclk,
    input  wire logic                             presetn,
    // APB slave
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [dma_channel_pkg::APB_AW-1:0] paddr,
    input  wire logic [31:0]                      pwdata,
    output logic      [31:0]                      prdata,
    output logic                                  pready,
    output logic                                  pslverr,
    // Peripheral requests and per-item acknowledge
    input  wire logic [NCH-1:0]                   xfer_req,
    output logic      [NCH-1:0]                   xfer_ack,
    // System bus master
    output logic                                  bus_req,
    output logic                                  bus_write,
    output logic      [31:0]                      bus_addr,
    output logic      [1:0]                       bus_size,
    output logic      [31:0]                      bus_wdata,
    input  wire logic [31:0]                      bus_rdata,
    input  wire logic                             bus_ack,
    input  wire logic                             bus_err,
    // Gated channel interrupts
    output logic      [NCH-1:0]                   irq
);
    import dma_channel_pkg::*;

    localparam int CW = $clog2(NCH) > 0 ? $clog2(NCH) : 1;

    logic [CFG_W-1:0] cfg_r    [NCH];
    logic [CNT_W-1:0] cnt_r    [NCH];
    logic [CNT_W-1:0] reload_r [NCH];
    logic [31:0]      pbase_r  [NCH];
    logic [31:0]      mbase_r  [NCH];
    logic [31:0]      pcur_r   [NCH];
    logic [31:0]      mcur_r   [NCH];
    logic [NCH-1:0]   cmp_r;
    logic [NCH-1:0]   half_r;
    logic [NCH-1:0]   err_r;

    state_type        state_r;
    logic [CW-1:0]    act_r;
    logic             bus_req_r;
    logic             bus_write_r;
    logic [31:0]      bus_addr_r;
    logic [1:0]       bus_size_r;
    logic [31:0]      bus_wdata_r;
    logic [NCH-1:0]   xfer_ack_r;
    logic [NCH-1:0]   irq_r;
    logic [31:0]      prdata_r;
    logic             pready_r;
    logic             pslverr_r;

    // Aligns an address to the item width
    function automatic logic [31:0] align(input logic [31:0] a,
                                          input logic [1:0]  sz);
        logic [31:0] r;
        r = a;
        if (sz == SIZE_32) begin
            r[1:0] = 2'b00;
        end else if (sz == SIZE_16) begin
            r[0] = 1'b0;
        end
        return r;
    endfunction

    // APB decode
    wire [3:0]  reg_ofs  = {paddr[3:2], 2'b00};
    wire [3:0]  ch_field = paddr[7:4];
    wire        in_chan  = (paddr[7] == 1'b0) &&
                           (32'(ch_field) < NCH);
    wire [CW-1:0] sel_ch = ch_field[CW-1:0];
    wire        is_stat  = (paddr == FLAG_STATUS_OFS);
    wire        is_clr   = (paddr == FLAG_CLEAR_OFS);
    wire        mapped   = in_chan || is_stat || is_clr;
    wire        apb_fin  = psel && penable && pready_r;
    wire        wr_ev    = apb_fin && pwrite && mapped;
    wire        wr_cfg   = wr_ev && in_chan && (reg_ofs == CFG_OFS);
    wire        wr_cnt   = wr_ev && in_chan && (reg_ofs == CNT_OFS);
    wire        wr_pb    = wr_ev && in_chan && (reg_ofs == PADDR_OFS);
    wire        wr_mb    = wr_ev && in_chan && (reg_ofs == MADDR_OFS);
    wire        wr_clr   = wr_ev && is_clr;

    // Flag status image, one nibble per channel
    logic [31:0] stat_img;
    always_comb begin
        stat_img = 32'h0;
        for (int c = 0; c < NCH; c++) begin
            stat_img[c*FLAG_W+ANY_POS]  = cmp_r[c] | half_r[c] | err_r[c];
            stat_img[c*FLAG_W+CMP_POS]  = cmp_r[c];
            stat_img[c*FLAG_W+HALF_POS] = half_r[c];
            stat_img[c*FLAG_W+ERR_POS]  = err_r[c];
        end
    end

    // Read mux; the clear register reads as zero
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        if (is_stat) begin
            rd_mux = stat_img;
        end else if (in_chan && reg_ofs == CFG_OFS) begin
            rd_mux = {17'h0, cfg_r[sel_ch]};
        end else if (in_chan && reg_ofs == CNT_OFS) begin
            rd_mux = {16'h0, cnt_r[sel_ch]};
        end else if (in_chan && reg_ofs == PADDR_OFS) begin
            rd_mux = pbase_r[sel_ch];
        end else if (in_chan && reg_ofs == MADDR_OFS) begin
            rd_mux = mbase_r[sel_ch];
        end
    end

    // One wait state: answer at the second access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0;
        end else begin
            pready_r  <= psel && penable && !pready_r;
            pslverr_r <= psel && penable && !pready_r && !mapped;
            if (psel && !penable) begin
                prdata_r <= rd_mux;
            end
        end
    end

    // Channel eligibility and arbitration
    logic [NCH-1:0] ready;
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            ready[c] = cfg_r[c][EN_BIT] &&
                       (cnt_r[c] != '0) &&
                       (cfg_r[c][COPY_BIT] || xfer_req[c]);
        end
    end

    logic [CW-1:0] win;
    logic [1:0]    win_rank;
    logic          any_ready;
    always_comb begin
        win       = '0;
        win_rank  = 2'b00;
        any_ready = 1'b0;
        for (int c = 0; c < NCH; c++) begin
            // Strictly greater keeps the lower index on a tie
            if (ready[c] && (!any_ready ||
                cfg_r[c][RANK_LSB+:2] > win_rank)) begin
                win       = CW'(c);
                win_rank  = cfg_r[c][RANK_LSB+:2];
                any_ready = 1'b1;
            end
        end
    end

    // Source and destination of the winning and active channels
    wire         w_dir  = cfg_r[win][DIR_BIT];
    wire [1:0]   w_psz  = cfg_r[win][PW_LSB+:2];
    wire [1:0]   w_msz  = cfg_r[win][MW_LSB+:2];
    wire [31:0]  w_src  = w_dir ? align(mcur_r[win], w_msz)
                                : align(pcur_r[win], w_psz);
    wire [1:0]   w_ssz  = w_dir ? w_msz : w_psz;
    wire         a_dir  = cfg_r[act_r][DIR_BIT];
    wire [1:0]   a_psz  = cfg_r[act_r][PW_LSB+:2];
    wire [1:0]   a_msz  = cfg_r[act_r][MW_LSB+:2];
    wire [31:0]  a_dst  = a_dir ? align(pcur_r[act_r], a_psz)
                                : align(mcur_r[act_r], a_msz);
    wire [1:0]   a_dsz  = a_dir ? a_psz : a_msz;

    wire item_done = (state_r == S_WRITE) && bus_ack && !bus_err;
    wire item_err  = (state_r != S_IDLE) && bus_err;

    // Transfer engine: read the source item, then write it out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r     <= S_IDLE;
            act_r       <= '0;
            bus_req_r   <= 1'b0;
            bus_write_r <= 1'b0;
            bus_addr_r  <= 32'h0;
            bus_size_r  <= 2'b00;
            bus_wdata_r <= 32'h0;
        end else begin
            case (state_r)
                S_IDLE: begin
                    if (any_ready) begin
                        act_r       <= win;
                        bus_req_r   <= 1'b1;
                        bus_write_r <= 1'b0;
                        bus_addr_r  <= w_src;
                        bus_size_r  <= w_ssz;
                        state_r     <= S_READ;
                    end
                end
                S_READ: begin
                    if (bus_err) begin
                        bus_req_r <= 1'b0;
                        state_r   <= S_IDLE;
                    end else if (bus_ack) begin
                        bus_write_r <= 1'b1;
                        bus_addr_r  <= a_dst;
                        bus_size_r  <= a_dsz;
                        bus_wdata_r <= bus_rdata;
                        state_r     <= S_WRITE;
                    end
                end
                S_WRITE: begin
                    if (bus_err || bus_ack) begin
                        bus_req_r   <= 1'b0;
                        bus_write_r <= 1'b0;
                        state_r     <= S_IDLE;
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // Per-channel registers, counters, addresses and flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int c = 0; c < NCH; c++) begin
                cfg_r[c]    <= CFG_RST;
                cnt_r[c]    <= CNT_RST;
                reload_r[c] <= CNT_RST;
                pbase_r[c]  <= ADDR_RST;
                mbase_r[c]  <= ADDR_RST;
                pcur_r[c]   <= ADDR_RST;
                mcur_r[c]   <= ADDR_RST;
            end
            cmp_r      <= '0;
            half_r     <= '0;
            err_r      <= '0;
            xfer_ack_r <= '0;
            irq_r      <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                logic        hit;
                logic        set_c;
                logic        set_h;
                logic        set_e;
                logic [CNT_W-1:0] dec;
                logic [31:0] pstep;
                logic [31:0] mstep;
                hit   = (CW'(c) == act_r);
                dec   = cnt_r[c] - 16'h0001;
                pstep = 32'h1 << cfg_r[c][PW_LSB+:2];
                mstep = 32'h1 << cfg_r[c][MW_LSB+:2];
                set_c = 1'b0;
                set_h = 1'b0;
                set_e = hit && item_err;
                // Reserved bits are not stored; software keeps them zero
                if (wr_cfg && sel_ch == CW'(c)) begin
                    cfg_r[c] <= pwdata[CFG_W-1:0];
                end else if (set_e) begin
                    cfg_r[c][EN_BIT] <= 1'b0;
                end
                if (wr_pb && sel_ch == CW'(c)) begin
                    pbase_r[c] <= pwdata;
                end
                if (wr_mb && sel_ch == CW'(c)) begin
                    mbase_r[c] <= pwdata;
                end
                if (wr_cnt && sel_ch == CW'(c) &&
                    !cfg_r[c][EN_BIT]) begin
                    cnt_r[c]    <= pwdata[CNT_W-1:0];
                    reload_r[c] <= pwdata[CNT_W-1:0];
                end else if (hit && item_done) begin
                    set_h = (dec == (reload_r[c] >> 1));
                    set_c = (dec == '0);
                    if (set_c && cfg_r[c][WRAP_BIT]) begin
                        cnt_r[c] <= reload_r[c];
                    end else begin
                        cnt_r[c] <= dec;
                    end
                end
                // Working addresses follow the bases while disabled
                if (!cfg_r[c][EN_BIT] ||
                    (set_c && cfg_r[c][WRAP_BIT])) begin
                    pcur_r[c] <= pbase_r[c];
                    mcur_r[c] <= mbase_r[c];
                end else if (hit && item_done) begin
                    if (cfg_r[c][PSTEP_BIT]) begin
                        pcur_r[c] <= pcur_r[c] + pstep;
                    end
                    if (cfg_r[c][MSTEP_BIT]) begin
                        mcur_r[c] <= mcur_r[c] + mstep;
                    end
                end
                // A new event wins over a clear in the same cycle
                cmp_r[c]  <= set_c || (cmp_r[c] && !(wr_clr &&
                    (pwdata[c*FLAG_W+ANY_POS] ||
                     pwdata[c*FLAG_W+CMP_POS])));
                half_r[c] <= set_h || (half_r[c] && !(wr_clr &&
                    (pwdata[c*FLAG_W+ANY_POS] ||
                     pwdata[c*FLAG_W+HALF_POS])));
                err_r[c]  <= set_e || (err_r[c] && !(wr_clr &&
                    (pwdata[c*FLAG_W+ANY_POS] ||
                     pwdata[c*FLAG_W+ERR_POS])));
                xfer_ack_r[c] <= hit && item_done;
                irq_r[c] <= (cmp_r[c]  && cfg_r[c][CMPIE_BIT])  ||
                            (half_r[c] && cfg_r[c][HALFIE_BIT]) ||
                            (err_r[c]  && cfg_r[c][ERRIE_BIT]);
            end
        end
    end

    assign prdata    = prdata_r;
    assign pready    = pready_r;
    assign pslverr   = pslverr_r;
    assign xfer_ack  = xfer_ack_r;
    assign bus_req   = bus_req_r;
    assign bus_write = bus_write_r;
    assign bus_addr  = bus_addr_r;
    assign bus_size  = bus_size_r;
    assign bus_wdata = bus_wdata_r;
    assign irq       = irq_r;
endmodule
`default_nettype wire

// >>> hdl/dma_channel_pkg.sv
// Constants shared by the channel control block: register map, field
// positions, reset values and engine states.
// Assumes a 32-bit APB slave and one system clock.
`default_nettype none
package dma_channel_pkg;
    // Register offsets inside a channel window
    localparam logic [3:0] CFG_OFS   = 4'h0;
    localparam logic [3:0] CNT_OFS   = 4'h4;
    localparam logic [3:0] PADDR_OFS = 4'h8;
    localparam logic [3:0] MADDR_OFS = 4'hc;
    // Channel windows and the shared flag registers
    localparam int         CH_STRIDE_SHIFT = 4;
    localparam logic [7:0] FLAG_STATUS_OFS = 8'h80;
    localparam logic [7:0] FLAG_CLEAR_OFS  = 8'h84;
    localparam int         APB_AW          = 8;
    // Configuration field positions
    localparam int EN_BIT    = 0;
    localparam int CMPIE_BIT = 1;
    localparam int HALFIE_BIT = 2;
    localparam int ERRIE_BIT = 3;
    localparam int DIR_BIT   = 4;
    localparam int WRAP_BIT  = 5;
    localparam int PSTEP_BIT = 6;
    localparam int MSTEP_BIT = 7;
    localparam int PW_LSB    = 8;
    localparam int MW_LSB    = 10;
    localparam int RANK_LSB  = 12;
    localparam int COPY_BIT  = 14;
    localparam int CFG_W     = 15;
    localparam int CNT_W     = 16;
    // Flag layout per channel nibble
    localparam int ANY_POS   = 0;
    localparam int CMP_POS   = 1;
    localparam int HALF_POS  = 2;
    localparam int ERR_POS   = 3;
    localparam int FLAG_W    = 4;
    // Item widths
    localparam logic [1:0] SIZE_16 = 2'b01;
    localparam logic [1:0] SIZE_32 = 2'b10;
    // Reset values
    localparam logic [CFG_W-1:0] CFG_RST  = 15'h0000;
    localparam logic [CNT_W-1:0] CNT_RST  = 16'h0000;
    localparam logic [31:0]      ADDR_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        S_IDLE,
        S_READ,
        S_WRITE
    } state_type;
endpackage
`default_nettype wire

// >>> tb/dma_channel_control_sva.sv
// Checker for the DMA channel block: APB timing, slave errors,
// bus item sequencing and alignment.
// Sees only the top ports; bound in at the foot of this file.
`default_nettype none
module dma_channel_control_sva
    import dma_channel_pkg::*;
#(
    parameter int NCH = 4
) (
    // Clock and reset
    input wire logic              pclk,
    input wire logic              presetn,
    // APB slave side
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // Items and system bus
    input wire logic [NCH-1:0]    xfer_ack,
    input wire logic              bus_req,
    input wire logic              bus_write,
    input wire logic [31:0]       bus_addr,
    input wire logic [1:0]        bus_size,
    input wire logic [31:0]       bus_wdata,
    input wire logic [31:0]       bus_rdata,
    input wire logic              bus_ack,
    input wire logic              bus_err
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       unmapped;
    logic       wdone_r;
    logic [7:0] rd_r;

    assign unmapped = paddr[7] ? (paddr > FLAG_CLEAR_OFS)
                               : (32'(paddr[6:4]) >= NCH);

    // Registered copies avoid $past on expressions
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdone_r <= 1'b0;
            rd_r    <= 8'h00;
        end else begin
            wdone_r <= bus_req && bus_write && bus_ack;
            rd_r    <= bus_rdata[7:0];
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_one_wait;
        !pready ##1 pready;
    endsequence
    sequence s_read_done;
        bus_req && !bus_write && bus_ack;
    endsequence
    sequence s_write_done;
        bus_req && bus_write && bus_ack;
    endsequence

    a_apb_wait: assert property (psel && !penable |=> s_one_wait)
        else $error("pready not in second access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_slverr_map: assert property (pready && paddr[1:0] == 2'b00
        |-> pslverr == unmapped)
        else $error("pslverr does not match address map");
    a_slverr_read: assert property (pready && pslverr && !pwrite
        |-> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_req_hold: assert property (bus_req && !bus_ack && !bus_err
        |=> bus_req && $stable(bus_addr) && $stable(bus_size))
        else $error("bus request changed before answer");
    a_read_write: assert property (s_read_done
        |=> bus_req && bus_write && bus_wdata[7:0] == rd_r)
        else $error("write phase missing or data changed");
    a_item_close: assert property (s_write_done
        |=> !bus_req && $onehot(xfer_ack))
        else $error("item not closed after write answer");
    a_ack_cause: assert property (xfer_ack != '0 |-> wdone_r)
        else $error("item acknowledge without write answer");
    a_err_drop: assert property (bus_req && bus_err
        |=> !bus_req && xfer_ack == '0)
        else $error("item not abandoned on bus error");
    a_addr_align: assert property (bus_req
        |-> !(bus_size == SIZE_32 && bus_addr[1:0] != 2'b00)
            && !(bus_size == SIZE_16 && bus_addr[0]) && bus_size != 2'b11)
        else $error("bus address not aligned to item size");
endmodule

bind dma_channel_control dma_channel_control_sva #(.NCH(NCH)) u_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .xfer_ack(xfer_ack), .bus_req(bus_req),
    .bus_write(bus_write), .bus_addr(bus_addr), .bus_size(bus_size),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
    .bus_err(bus_err)
);
`default_nettype wire

// >>> tb/dma_bus_memory.sv
// Memory and peripheral model on the system bus side.
// Answers each phase with a one-cycle ack, or an error when told.
`default_nettype none
module dma_bus_memory (
    // Clock and reset
    input wire logic   pclk,
    input wire logic   presetn,
    // Bench controls
    input wire logic   slow,
    input wire logic   fail,
    // System bus slave
    input wire logic   bus_req,
    input wire logic [31:0] bus_addr,
    output logic [31:0] bus_rdata,
    output logic       bus_ack,
    output logic       bus_err
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] DATA_KEY = 32'h3c3c_a5a5;
    logic [2:0]  wait_r;
    logic [31:0] cyc_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_r  <= 3'h0;
            bus_ack <= 1'b0;
            bus_err <= 1'b0;
            cyc_r   <= 32'h0;
        end else begin
            cyc_r   <= cyc_r + 32'h1;
            bus_ack <= 1'b0;
            bus_err <= 1'b0;
            if (bus_req && !bus_ack && !bus_err) begin
                if (wait_r != 3'h0) begin
                    wait_r <= wait_r - 3'h1;
                end else begin
                    bus_ack <= !fail;
                    bus_err <= fail;
                    wait_r  <= slow ? 3'h3 : 3'h0;
                end
            end
        end
    end
    // Outside an answer the data lines wander so stale data shows up
    assign bus_rdata = bus_ack ? (bus_addr ^ DATA_KEY) : cyc_r;
endmodule
`default_nettype wire

// >>> tb/dma_channel_control_tb.sv
// Self-checking bench for the DMA channel block.
// Assumes the bus memory model and the bound checker.
`default_nettype none
module dma_channel_control_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import dma_channel_pkg::*;
    localparam int NCH = 4;
    localparam int LIMIT = 20000;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, slow = 1'b0, fail = 1'b0, errv;
    logic pready, pslverr, bus_req, bus_write, bus_ack, bus_err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdv, pb, mb;
    logic [31:0] bus_addr, bus_wdata, bus_rdata;
    logic [NCH-1:0] xfer_req = '0, xfer_ack, irq;
    logic [1:0] bus_size;
    logic [31:0] ra[$], wa[$], wd[$];
    logic [NCH-1:0] acks[$];
    logic [1:0] rk1[4] = '{2'h0, 2'h3, 2'h2, 2'h1};
    logic [1:0] rk2[4] = '{2'h1, 2'h2, 2'h2, 2'h3};
    int seed = 32'hfc10, bad_count = 0, checks_done = 0, cyc = 0;

    always #2.5 pclk = ~pclk;
    dma_channel_control #(.NCH(NCH)) u_dma_channel_control (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .xfer_req(xfer_req),
        .xfer_ack(xfer_ack), .bus_req(bus_req), .bus_write(bus_write),
        .bus_addr(bus_addr), .bus_size(bus_size), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .bus_ack(bus_ack), .bus_err(bus_err),
        .irq(irq));
    dma_bus_memory u_dma_bus_memory (.pclk(pclk), .presetn(presetn),
        .slow(slow), .fail(fail), .bus_req(bus_req), .bus_addr(bus_addr),
        .bus_rdata(bus_rdata), .bus_ack(bus_ack), .bus_err(bus_err));

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            bad_count++;
            test_done();
        end
        if (bus_req === 1'b1 && bus_ack === 1'b1) begin
            if (bus_write) begin
                wa.push_back(bus_addr);
                wd.push_back(bus_wdata);
                slow <= 1'($random(seed));
            end else begin
                ra.push_back(bus_addr);
            end
        end
        if (xfer_ack != '0) acks.push_back(xfer_ack);
    end

    function automatic logic [31:0] exp_data(input logic [31:0] a);
        return a ^ 32'h3c3c_a5a5;
    endfunction

    task automatic cmp(input logic [31:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        cmp(rdv, e);
    endtask
    // Items repeat with period p, as after a wraparound reload
    task automatic items(input logic [31:0] s, d, ss, sd, m,
                         input int n, p);
        for (int i = 0; i < n; i++) begin
            cmp(ra[i], s + ss * (i % p));
            cmp(wa[i], d + sd * (i % p));
            cmp(wd[i] & m, exp_data(s + ss * (i % p)) & m);
        end
        ra.delete();
        wa.delete();
        wd.delete();
    endtask
    task automatic test_done;
        if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int c = 0; c < NCH; c++) begin
            for (int r = 0; r < 4; r++) chk(8'(16 * c + 4 * r), 32'h0);
        end
        wr(8'h40, 32'h1234_5678);
        cmp(32'(errv), 32'h1);
        chk(8'h40, 32'h0);
        pb = $random(seed);
        mb = $random(seed);
        wr(8'h18, pb);
        wr(8'h1c, mb);
        wr(8'h14, 32'h0000_ffff);
        wr(8'h10, 32'h0000_7ffe);
        chk(8'h18, pb);
        chk(8'h1c, mb);
        chk(8'h14, 32'h0000_ffff);
        chk(8'h10, 32'h0000_7ffe);
        // Memory copy, 32-bit items, both sides stepping
        wr(8'h08, pb);
        wr(8'h0c, mb);
        wr(8'h04, 32'h4);
        wr(8'h00, 32'h0000_4ac7);
        while (wa.size() < 4) @(posedge pclk);
        repeat (3) @(posedge pclk);
        items(pb & ~32'h3, mb & ~32'h3, 4, 4, '1, 4, 4);
        chk(8'h04, 32'h0);
        chk(8'h80, 32'h7);
        cmp(32'(irq), 32'h1);
        wr(8'h04, 32'h5);
        chk(8'h04, 32'h0);
        wr(8'h84, 32'h0);
        chk(8'h80, 32'h7);
        wr(8'h84, 32'h2);
        chk(8'h80, 32'h5);
        wr(8'h84, 32'h1);
        chk(8'h80, 32'h0);
        cmp(32'(irq), 32'h0);
        wr(8'h00, 32'h0);
        // Peripheral requests, memory to peripheral, fixed 16-bit places
        wr(8'h28, pb | 32'h1);
        wr(8'h2c, mb | 32'h1);
        wr(8'h24, 32'h3);
        wr(8'h20, 32'h0000_0511);
        xfer_req <= 4'b0100;
        while (wa.size() < 3) @(posedge pclk);
        repeat (20) @(posedge pclk);
        xfer_req <= 4'b0000;
        cmp(32'(wa.size()), 32'h3);
        items(mb & ~32'h1, pb & ~32'h1, 0, 0, 32'hffff, 3, 3);
        chk(8'h80, 32'h700);
        cmp(32'(irq), 32'h0);
        wr(8'h84, 32'h100);
        wr(8'h20, 32'h0);
        // Bus error in the read phase
        wr(8'h14, 32'h2);
        fail <= 1'b1;
        wr(8'h10, 32'h0000_4009);
        repeat (20) @(posedge pclk);
        fail <= 1'b0;
        chk(8'h10, 32'h0000_4008);
        chk(8'h14, 32'h2);
        chk(8'h80, 32'h90);
        cmp(32'(irq), 32'h2);
        wr(8'h84, 32'h10);
        // Wraparound: count and addresses reload
        wr(8'h38, pb);
        wr(8'h3c, mb);
        wr(8'h34, 32'h2);
        wr(8'h30, 32'h0000_4ae1);
        while (wa.size() < 5) @(posedge pclk);
        wr(8'h30, 32'h0);
        repeat (20) @(posedge pclk);
        items(pb & ~32'h3, mb & ~32'h3, 4, 4, '1, 5, 2);
        // Arbitration over every rank, one tie
        for (int i = 0; i < 4; i++) begin
            wr(8'h14, 32'h1);
            wr(8'h24, 32'h1);
            wr(8'h10, 32'h1 | (32'(rk1[i]) << 12));
            wr(8'h20, 32'h1 | (32'(rk2[i]) << 12));
            acks.delete();
            xfer_req <= 4'b0110;
            while (acks.size() < 2) @(posedge pclk);
            xfer_req <= 4'b0000;
            cmp(32'(acks[0]), (rk2[i] > rk1[i]) ? 32'h4 : 32'h2);
            wr(8'h10, 32'h0);
            wr(8'h20, 32'h0);
        end
        test_done();
    end
endmodule
`default_nettype wire
